/* File: rtl/dsm_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - host commands only via control word; status readback
// - transitions by command or detected error
// - groups: power disabled, enabled, fault
// - power-up self-init, then toward ready state
// - self-test state, communication off
// - switch-on-disabled after test, communication on
// - ready energises stage; switched-on turns stage on
// - operation enabled applies and regulates motor
// - fast halt runs quick-stop function
// - critical error goes straight to fault, except during self-test
// - non-critical error enters fault reaction from any non-fault state but self-test
// - fault reaction keeps motor voltage regulated
// - fault removes motor voltage, stage blocked
// - decode commands from control word bits 3..0
// - fault reset on bit 7 rising edge
module dsm_top
    import dsm_pkg::*;
#(
    parameter int SELFTEST_CYCLES = DSM_SELFTEST_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic err_critical,
    input wire logic err_noncritical,
    input wire logic fault_reaction_done,
    input wire logic fast_halt_done,
    output logic comm_enable,
    output logic stage_power,
    output logic stage_on,
    output logic motor_voltage,
    output logic fast_halt_run,
    output logic fault_react_run,
    output logic irq
);
    typedef struct packed {
        dsm_state_t state;
        logic [15:0] ctrl;
        logic cw_new;
        logic cw_b7_prev;
        logic err_crit;
        logic err_nc;
        logic [DSM_IRQ_W-1:0] irq_stat;
        logic [DSM_IRQ_W-1:0] irq_en;
        dsm_ahb_req_t ap;
        logic [31:0] rdata;
        dsm_drive_t drv;
        logic irq;
    } dsm_regs_t;

    dsm_regs_t r;
    dsm_regs_t next_r;
    dsm_cmd_t cmd;
    logic st_done;
    logic [31:0] status_word;
    logic ap_valid;

    dsm_cmd_decode u_dec (
        .cw_low(r.ctrl[3:0]),
        .cmd(cmd)
    );

    dsm_selftest #(
        .CYCLES(SELFTEST_CYCLES)
    ) u_st (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .run(r.state == selftest_state),
        .done(st_done)
    );

    // ------------------------------------------------------------
    // status word: state, drive flags, group
    // ------------------------------------------------------------
    function automatic dsm_group_t grp_of(dsm_state_t s);
        unique case (s)
            fault_reaction_state, fault_state: grp_of = dsm_grp_fault;
            switched_on_state, op_enabled_state, fast_halt_state: grp_of = dsm_grp_power_enabled;
            default: grp_of = dsm_grp_power_disabled;
        endcase
    endfunction

    always_comb begin
        status_word = '0;
        status_word[DSM_ST_STATE_LSB +: 4] = r.state;
        status_word[DSM_ST_COMM_BIT] = r.drv.comm_ok;
        status_word[DSM_ST_STAGE_PWR_BIT] = r.drv.stage_powered;
        status_word[DSM_ST_STAGE_ON_BIT] = r.drv.stage_on;
        status_word[DSM_ST_MOTOR_V_BIT] = r.drv.motor_voltage;
        status_word[DSM_ST_GROUP_LSB +: 2] = grp_of(r.state);
    end

    assign ap_valid = hsel && hready && htrans == DSM_HTRANS_NONSEQ;

    // ------------------------------------------------------------
    // bus, command and state logic
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.cw_new = 1'b0;
        // capture address phase
        next_r.ap.hsel = ap_valid;
        next_r.ap.haddr = haddr[7:0];
        next_r.ap.hwrite = hwrite;
        next_r.ap.htrans = htrans;
        next_r.ap.hwdata = '0;
        if (ap_valid && !hwrite) begin
            unique case (haddr[7:0])
                DSM_CTRL_OFS: next_r.rdata = {16'h0000, r.ctrl};
                DSM_STAT_OFS: next_r.rdata = status_word;
                DSM_IRQ_STAT_OFS: next_r.rdata = 32'(r.irq_stat);
                DSM_IRQ_EN_OFS: next_r.rdata = 32'(r.irq_en);
                DSM_ERR_OFS: next_r.rdata = 32'({r.err_nc, r.err_crit});
                default: next_r.rdata = '0;
            endcase
        end
        // data phase writes; control word gated until comm is up
        if (r.ap.hsel && r.ap.hwrite) begin
            unique case (r.ap.haddr)
                DSM_CTRL_OFS: begin
                    if (r.drv.comm_ok) begin
                        next_r.ctrl = hwdata[15:0];
                        next_r.cw_new = 1'b1;
                    end
                end
                DSM_IRQ_EN_OFS: next_r.irq_en = hwdata[DSM_IRQ_W-1:0];
                DSM_IRQ_CLR_OFS: next_r.irq_stat = r.irq_stat & ~hwdata[DSM_IRQ_W-1:0];
                default: ;
            endcase
        end
        // error latches, cleared by fault reset
        if (err_critical) next_r.err_crit = 1'b1;
        if (err_noncritical) next_r.err_nc = 1'b1;
        next_r.cw_b7_prev = r.ctrl[DSM_CW_FAULT_RESET_BIT];
        unique case (r.state)
            selftest_state: begin
                if (st_done) next_r.state = switch_on_disabled_state;
            end
            fault_reaction_state: begin
                if (fault_reaction_done || r.err_crit) next_r.state = fault_state;
            end
            fault_state: begin
                if (r.ctrl[DSM_CW_FAULT_RESET_BIT] && !r.cw_b7_prev && !err_critical
                        && !err_noncritical) begin
                    next_r.state = switch_on_disabled_state;
                    next_r.err_crit = 1'b0;
                    next_r.err_nc = 1'b0;
                end
            end
            default: begin
                if (err_critical) begin
                    next_r.state = fault_state;
                end else if (err_noncritical) begin
                    next_r.state = fault_reaction_state;
                end else if (r.cw_new) begin
                    // unmatched commands fall through unchanged
                    unique case (r.state)
                        switch_on_disabled_state:
                            if (cmd.shutdown) next_r.state = stage_energised_state;
                        stage_energised_state:
                            if (cmd.disable_voltage || cmd.quick_stop)
                                next_r.state = switch_on_disabled_state;
                            else if (cmd.switch_on) next_r.state = switched_on_state;
                        switched_on_state:
                            if (cmd.disable_voltage || cmd.quick_stop)
                                next_r.state = switch_on_disabled_state;
                            else if (cmd.shutdown) next_r.state = stage_energised_state;
                            else if (cmd.enable_op) next_r.state = op_enabled_state;
                        op_enabled_state:
                            if (cmd.disable_voltage) next_r.state = switch_on_disabled_state;
                            else if (cmd.quick_stop) next_r.state = fast_halt_state;
                            else if (cmd.shutdown) next_r.state = stage_energised_state;
                            else if (cmd.disable_op) next_r.state = switched_on_state;
                        fast_halt_state:
                            if (cmd.disable_voltage) next_r.state = switch_on_disabled_state;
                        default: ;
                    endcase
                end else if (r.state == fast_halt_state && fast_halt_done) begin
                    next_r.state = switch_on_disabled_state;
                end
            end
        endcase
        // drive outputs follow next state
        next_r.drv.comm_ok = next_r.state != selftest_state;
        next_r.drv.stage_powered = next_r.state inside {stage_energised_state,
            switched_on_state, op_enabled_state, fast_halt_state,
            fault_reaction_state};
        next_r.drv.stage_on = next_r.state inside {switched_on_state,
            op_enabled_state, fast_halt_state, fault_reaction_state};
        next_r.drv.motor_voltage = next_r.state inside {op_enabled_state,
            fast_halt_state, fault_reaction_state};
        next_r.drv.fast_halt_run = next_r.state == fast_halt_state;
        next_r.drv.fault_react_run = next_r.state == fault_reaction_state;
        // sticky events; set wins over clear
        if (next_r.state != r.state) next_r.irq_stat[DSM_IRQ_STATE_BIT] = 1'b1;
        if (next_r.state == fault_state && r.state != fault_state)
            next_r.irq_stat[DSM_IRQ_FAULT_BIT] = 1'b1;
        if (r.state == fault_state && next_r.state != fault_state)
            next_r.irq_stat[DSM_IRQ_FRESET_BIT] = 1'b1;
        next_r.irq = |(next_r.irq_stat & next_r.irq_en);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
            r.state <= selftest_state;
            r.ctrl <= DSM_CW_RESET_VAL;
        end else begin
            r <= next_r;
        end
    end

    assign hrdata = r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign comm_enable = r.drv.comm_ok;
    assign stage_power = r.drv.stage_powered;
    assign stage_on = r.drv.stage_on;
    assign motor_voltage = r.drv.motor_voltage;
    assign fast_halt_run = r.drv.fast_halt_run;
    assign fault_react_run = r.drv.fault_react_run;
    assign irq = r.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence crit_seen;
        err_critical && r.state inside {switch_on_disabled_state, stage_energised_state,
            switched_on_state, op_enabled_state, fast_halt_state};
    endsequence

    crit_to_fault_a: assert property (crit_seen |=> r.state == fault_state)
        else $error("critical error did not reach fault");
    nc_to_react_a: assert property (!err_critical && err_noncritical
        && r.state == op_enabled_state |=> r.state == fault_reaction_state)
        else $error("noncritical error did not reach fault reaction");
    fault_no_volt_a: assert property (r.state == fault_state
        |-> !motor_voltage && !stage_on)
        else $error("voltage in fault");
    react_volt_a: assert property (r.state == fault_reaction_state |-> motor_voltage)
        else $error("no voltage in fault reaction");
    op_volt_a: assert property (r.state == op_enabled_state
        |-> motor_voltage && stage_on)
        else $error("no voltage in operation");
    selftest_quiet_a: assert property (r.state == selftest_state
        |-> !comm_enable && !stage_on)
        else $error("comm or stage active in selftest");
    ready_state_a: assert property (r.state == stage_energised_state |->
        stage_power && !stage_on && !motor_voltage)
        else $error("ready state drive wrong");
    halt_run_a: assert property (r.state == fast_halt_state |-> fast_halt_run)
        else $error("fast halt not running");
    no_cmd_hold_a: assert property (!r.cw_new && !err_critical && !err_noncritical
        && r.state inside {stage_energised_state, switched_on_state, op_enabled_state}
        |=> $stable(r.state))
        else $error("state moved with no command");
    irq_level_a: assert property (##1 irq == |($past(next_r.irq_stat) & $past(next_r.irq_en)))
        else $error("irq level mismatch");

    // ------------------------------------------------------------
    // state entry, exit, drive and group checks
    // ------------------------------------------------------------
    sequence freset_ok;
        r.state == fault_state && r.ctrl[DSM_CW_FAULT_RESET_BIT] && !r.cw_b7_prev
            && !err_critical && !err_noncritical;
    endsequence

    sequence test_done;
        r.state == selftest_state && st_done;
    endsequence

    freset_exit_a: assert property (freset_ok |=> r.state == switch_on_disabled_state)
        else $error("fault reset did not leave fault");
    fault_hold_a: assert property (r.state == fault_state
        && !r.ctrl[DSM_CW_FAULT_RESET_BIT] |=> r.state == fault_state)
        else $error("fault left without reset edge");
    selftest_exit_a: assert property (test_done
        |=> r.state == switch_on_disabled_state && comm_enable)
        else $error("selftest end not followed by comm");
    sod_drive_a: assert property (r.state == switch_on_disabled_state
        |-> comm_enable && !stage_power && !motor_voltage)
        else $error("switch on disabled drive wrong");
    sw_on_drive_a: assert property (r.state == switched_on_state
        |-> stage_on && !motor_voltage)
        else $error("switched on drive wrong");
    react_run_a: assert property (r.state == fault_reaction_state
        |-> fault_react_run && stage_on)
        else $error("fault reaction not running");
    fault_group_a: assert property (r.state inside {fault_reaction_state, fault_state}
        |-> status_word[DSM_ST_GROUP_LSB +: 2] == dsm_grp_fault)
        else $error("fault group not reported");
    enable_op_a: assert property (r.cw_new && cmd.enable_op && r.state == switched_on_state
        && !err_critical && !err_noncritical |=> r.state == op_enabled_state)
        else $error("enable operation not taken");
endmodule
`default_nettype wire

/* File: rtl/dsm_pkg.sv */
package dsm_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] DSM_CTRL_OFS = 8'h00;
    localparam logic [7:0] DSM_STAT_OFS = 8'h04;
    localparam logic [7:0] DSM_IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] DSM_IRQ_EN_OFS = 8'h0c;
    localparam logic [7:0] DSM_IRQ_CLR_OFS = 8'h10;
    localparam logic [7:0] DSM_ERR_OFS = 8'h14;

    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int DSM_CW_FAULT_RESET_BIT = 7;
    localparam logic [15:0] DSM_CW_RESET_VAL = 16'h0006;
    localparam int DSM_ST_STATE_LSB = 0;
    localparam int DSM_ST_COMM_BIT = 4;
    localparam int DSM_ST_STAGE_PWR_BIT = 5;
    localparam int DSM_ST_STAGE_ON_BIT = 6;
    localparam int DSM_ST_MOTOR_V_BIT = 7;
    localparam int DSM_ST_GROUP_LSB = 8;
    localparam int DSM_ERR_CRIT_BIT = 0;
    localparam int DSM_ERR_NONCRIT_BIT = 1;
    localparam int DSM_IRQ_W = 3;
    localparam int DSM_IRQ_STATE_BIT = 0;
    localparam int DSM_IRQ_FAULT_BIT = 1;
    localparam int DSM_IRQ_FRESET_BIT = 2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int DSM_CLK_NS = 5;
    localparam int DSM_SELFTEST_NS = 1000;
    localparam int DSM_SELFTEST_CYC = (DSM_SELFTEST_NS + DSM_CLK_NS - 1) / DSM_CLK_NS;
    localparam logic [1:0] DSM_HTRANS_NONSEQ = 2'b10;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        selftest_state,
        switch_on_disabled_state,
        stage_energised_state,
        switched_on_state,
        op_enabled_state,
        fast_halt_state,
        fault_reaction_state,
        fault_state
    } dsm_state_t;

    typedef enum logic [1:0] {
        dsm_grp_power_disabled,
        dsm_grp_power_enabled,
        dsm_grp_fault
    } dsm_group_t;

    typedef struct packed {
        logic shutdown;
        logic switch_on;
        logic disable_voltage;
        logic quick_stop;
        logic disable_op;
        logic enable_op;
    } dsm_cmd_t;

    typedef struct packed {
        logic comm_ok;
        logic stage_powered;
        logic stage_on;
        logic motor_voltage;
        logic fast_halt_run;
        logic fault_react_run;
    } dsm_drive_t;

    typedef struct packed {
        logic [1:0] htrans;
        logic [7:0] haddr;
        logic hwrite;
        logic hsel;
        logic [31:0] hwdata;
    } dsm_ahb_req_t;

endpackage

/* File: rtl/dsm_cmd_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module dsm_cmd_decode
    import dsm_pkg::*;
(
    input wire logic [3:0] cw_low,
    output dsm_cmd_t cmd
);
    // ------------------------------------------------------------
    // command patterns on control word bits 3..0
    // ------------------------------------------------------------
    always_comb begin
        cmd.shutdown = cw_low[2:0] == 3'b110;
        cmd.switch_on = cw_low[2:0] == 3'b111;
        cmd.disable_voltage = !cw_low[1];
        cmd.quick_stop = cw_low[2:1] == 2'b01;
        cmd.disable_op = cw_low == 4'b0111;
        cmd.enable_op = cw_low == 4'b1111;
    end
endmodule
`default_nettype wire

/* File: rtl/dsm_selftest.sv */
`timescale 1ns/1ps
`default_nettype none
module dsm_selftest
    import dsm_pkg::*;
#(
    parameter int CYCLES = DSM_SELFTEST_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic run,
    output logic done
);
    typedef struct packed {
        logic [15:0] cnt;
        logic done;
    } dsm_st_regs_t;

    dsm_st_regs_t r;
    dsm_st_regs_t next_r;

    // ------------------------------------------------------------
    // self-test timer, counts while run holds
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        if (!run) begin
            next_r.cnt = '0;
            next_r.done = 1'b0;
        end else if (r.cnt == 16'(CYCLES - 1)) begin
            next_r.done = 1'b1;
        end else begin
            next_r.cnt = r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign done = r.done;
endmodule
`default_nettype wire

/* File: verification/dsm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dsm_host_model
    import dsm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // single word transfer; idle bus lines are scrambled on release
    // ------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, addr};
        htrans <= DSM_HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? wdata : ~hwdata;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rdata = hrdata;
        hwdata <= ~wdata;
        haddr <= ~haddr;
    endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
    import dsm_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic err_critical = 1'b0;
    logic err_noncritical = 1'b0;
    logic fault_reaction_done = 1'b0;
    logic fast_halt_done = 1'b0;
    logic comm_enable, stage_power, stage_on, motor_voltage, fast_halt_run, fault_react_run;
    int errors = 0;
    int cmp_count = 0;
    logic [3:0] st;
    logic [15:0] cw;
    logic [3:0] ladder [6] = '{4'h6, 4'h7, 4'hf, 4'h7, 4'hf, 4'h2};

    always #2.5 ref_clk = ~ref_clk;

    dsm_top #(.SELFTEST_CYCLES(4)) i_dsm_top (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .err_critical(err_critical), .err_noncritical(err_noncritical),
        .fault_reaction_done(fault_reaction_done), .fast_halt_done(fast_halt_done),
        .comm_enable(comm_enable), .stage_power(stage_power), .stage_on(stage_on),
        .motor_voltage(motor_voltage), .fast_halt_run(fast_halt_run),
        .fault_react_run(fault_react_run), .irq(irq));

    dsm_host_model i_dsm_host_model (.ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));

    // ------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------
    function automatic logic [3:0] exp_next(input logic [3:0] s, input logic [3:0] c);
        logic dv, qs, sd, so;
        dv = ~c[1];
        qs = c[1] & ~c[2];
        sd = c[2:0] == 3'b110;
        so = c[2:0] == 3'b111;
        case (s)
            4'h1: return sd ? 4'h2 : 4'h1;
            4'h2: return so ? 4'h3 : ((dv | qs) ? 4'h1 : 4'h2);
            4'h3: return (c == 4'hf) ? 4'h4 : (sd ? 4'h2 : ((dv | qs) ? 4'h1 : 4'h3));
            4'h4: return dv ? 4'h1 : (qs ? 4'h5 : (sd ? 4'h2 : ((c == 4'h7) ? 4'h3 : 4'h4)));
            4'h5: return dv ? 4'h1 : 4'h5;
            default: return s;
        endcase
    endfunction

    function automatic logic [9:0] exp_stat(input logic [3:0] s);
        logic [1:0] g;
        g = (s >= 4'h6) ? 2'h2 : ((s >= 4'h3) ? 2'h1 : 2'h0);
        return {g, s inside {[4:6]}, s inside {[3:6]}, s inside {[2:6]}, s != 4'h0, s};
    endfunction

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_dsm_host_model.xfer(1'b1, a, d, rdat);
    endtask

    task automatic rd(input logic [7:0] a);
        i_dsm_host_model.xfer(1'b0, a, 32'h0000_0000, rdat);
    endtask

    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic chk_state(input logic [3:0] s);
        logic [9:0] e;
        e = exp_stat(s);
        settle();
        rd(DSM_STAT_OFS);
        `CHK(rdat[9:0], e);
        `CHK({motor_voltage, stage_on, stage_power, comm_enable}, e[7:4]);
        `CHK(hresp, 1'b0);
        `CHK({fast_halt_run, fault_react_run}, {s == 4'h5, s == 4'h6});
    endtask

    // after a fixed settle, checks the status against each expected state before the next command
    task automatic cmd(input logic [15:0] c);
        wr(DSM_CTRL_OFS, {16'h0000, c});
        st = exp_next(st, c[3:0]);
        chk_state(st);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        results();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(14));
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        #1;
        `CHK({comm_enable, stage_power, stage_on, motor_voltage, irq}, 5'h00);
        wr(DSM_CTRL_OFS, 32'h0000_000f);
        repeat (20) @(posedge ref_clk);
        rd(DSM_CTRL_OFS);
        `CHK(rdat[15:0], DSM_CW_RESET_VAL);
        st = 4'h1;
        chk_state(st);
        cmd(16'h0007);
        cmd(16'h000f);
        $display("test selftest done");
        foreach (ladder[i]) cmd({12'h000, ladder[i]});
        fast_halt_done <= 1'b1;
        st = 4'h1;
        chk_state(st);
        fast_halt_done <= 1'b0;
        $display("test ladder done");
        repeat (40) begin
            cw = 16'(($urandom & 32'h0000_0070) | $urandom_range(0, 15));
            cmd(cw);
        end
        if (st == 4'h5) cmd(16'h0000);
        $display("test random done");
        wr(DSM_IRQ_CLR_OFS, 32'h0000_0007);
        wr(DSM_IRQ_EN_OFS, 32'h0000_0002);
        if (st != 4'h1) cmd(16'h0000);
        cmd(16'h0006);
        cmd(16'h0007);
        cmd(16'h000f);
        err_noncritical <= 1'b1;
        st = 4'h6;
        chk_state(st);
        fault_reaction_done <= 1'b1;
        st = 4'h7;
        chk_state(st);
        `CHK(irq, 1'b1);
        rd(DSM_ERR_OFS);
        `CHK(rdat[1:0], 2'b10);
        cmd(16'h0000);
        cmd(16'h0080);
        err_noncritical <= 1'b0;
        fault_reaction_done <= 1'b0;
        cmd(16'h0080);
        cmd(16'h0000);
        wr(DSM_CTRL_OFS, 32'h0000_0080);
        st = 4'h1;
        chk_state(st);
        rd(DSM_ERR_OFS);
        `CHK(rdat[1:0], 2'b00);
        $display("test fault reaction done");
        wr(DSM_IRQ_CLR_OFS, 32'h0000_0007);
        settle();
        `CHK(irq, 1'b0);
        wr(DSM_IRQ_EN_OFS, 32'h0000_0000);
        cmd(16'h0006);
        `CHK(irq, 1'b0);
        rd(DSM_IRQ_STAT_OFS);
        `CHK(rdat[2:0], 3'b001);
        wr(DSM_IRQ_EN_OFS, 32'h0000_0001);
        settle();
        `CHK(irq, 1'b1);
        wr(DSM_IRQ_CLR_OFS, 32'h0000_0001);
        settle();
        `CHK(irq, 1'b0);
        rd(8'h3c);
        `CHK(rdat, 32'h0000_0000);
        $display("test irq done");
        cmd(16'h0007);
        cmd(16'h000f);
        err_critical <= 1'b1;
        st = 4'h7;
        chk_state(st);
        rd(DSM_ERR_OFS);
        `CHK(rdat[0], 1'b1);
        err_critical <= 1'b0;
        cmd(16'h0000);
        wr(DSM_CTRL_OFS, 32'h0000_0080);
        st = 4'h1;
        chk_state(st);
        $display("test critical done");
        results();
    end
endmodule
`default_nettype wire
